// file: hdl/cml_cfg.svh
// Purpose: constants for the command mode and link diagnostics block
// Assumes: 200 MHz core clock, APB register access
// Notes:   offsets are byte addresses of 32-bit words
`ifndef CML_CFG_SVH
`define CML_CFG_SVH

`define CML_CLK_MHZ          200
`define CML_MS_TIME_US       1000
`define CML_MS_CYCLES        (`CML_MS_TIME_US * `CML_CLK_MHZ)
`define CML_DECI_TIME_MS     100
`define CML_DECI_MS_TICKS    (`CML_DECI_TIME_MS)

`define CML_OFS_HW_REV       8'h00
`define CML_OFS_RX_FAULT     8'h04
`define CML_OFS_RX_GOOD      8'h08
`define CML_OFS_TX_FAIL      8'h0C
`define CML_OFS_HOLD_TIME    8'h10
`define CML_OFS_JOIN_STATUS  8'h14
`define CML_OFS_IDLE_TIMEOUT 8'h18
`define CML_OFS_GUARD_TIME   8'h1C
`define CML_OFS_ESC_CHAR     8'h20
`define CML_OFS_MODE         8'h24
`define CML_OFS_IRQ_STATUS   8'h28
`define CML_OFS_IRQ_CLEAR    8'h2C
`define CML_OFS_IRQ_ENABLE   8'h30

`define CML_HW_REV_DEFAULT   16'h0A5C
`define CML_SAT_MAX          16'hFFFF
`define CML_HOLD_RST         8'h20
`define CML_HOLD_MIN         8'h01
`define CML_TIMEOUT_RST      16'h0064
`define CML_TIMEOUT_MIN      16'h0002
`define CML_GUARD_RST        16'h03E8
`define CML_ESC_RST          8'h2B
`define CML_ESC_COUNT        2'h3

`define CML_JS_OK            8'h00
`define CML_JS_NO_NET        8'h21
`define CML_JS_NO_MATCH      8'h22
`define CML_JS_REFUSED       8'h23
`define CML_JS_JOIN_FAIL     8'h27
`define CML_JS_COORD_FAIL    8'h2A
`define CML_JS_COORD_CHECK   8'h2B
`define CML_JS_NO_RESP       8'hAB
`define CML_JS_KEY_UNSEC     8'hAC
`define CML_JS_SCANNING      8'hFF

`define CML_IRQ_ENTER        0
`define CML_IRQ_EXIT         1
`define CML_IRQ_JOIN         2
`define CML_IRQ_W            3

`endif

// file: hdl/cml_core.sv
// Purpose: command mode entry/exit and link diagnostics registers
// Assumes: serial bytes, commands and radio events arrive as pulses
// Notes:   APB slave, one wait state on every access
`timescale 1ns/1ps
`default_nettype none
`include "cml_cfg.svh"
module cml_core
	import cml_pkg::*;
#(
	parameter int          MS_CYCLES = `CML_MS_CYCLES,
	parameter logic [15:0] HW_REV    = `CML_HW_REV_DEFAULT // Arbitrary
)
(
	input  wire logic        core_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output var  logic [31:0] prdata_o,
	output var  logic        pready_o,
	output var  logic        pslverr_o,
	input  wire logic [7:0]  rx_byte_i,
	input  wire logic        rx_byte_valid_i,
	input  wire logic        cmd_valid_i,
	input  wire logic        cmd_exit_i,
	input  wire logic        rx_fault_i,
	input  wire logic        rx_good_i,
	input  wire logic        tx_fail_i,
	input  wire logic        rx_frame_i,
	input  wire logic        join_event_valid_i,
	input  wire logic [3:0]  join_event_i,
	output var  logic        cmd_mode_o,
	output var  logic        strength_o,
	output var  logic        irq_o
);
	cml_tick_if tick ();

	cml_timebase #(.MS_CYCLES(MS_CYCLES)) u_timebase
	(
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.tick       (tick)
	);

	logic [31:0]          prdata_reg;
	logic                 pready_reg;
	logic                 pslverr_reg;
	logic [15:0]          sat_cnt_reg [3];
	logic [7:0]           hold_time_reg;
	logic [7:0]           hold_cnt_reg;
	logic                 strength_reg;
	logic [7:0]           join_status_reg;
	logic [15:0]          idle_timeout_reg;
	logic [15:0]          guard_time_reg;
	logic [7:0]           esc_char_reg;
	logic                 cmd_mode_reg;
	logic [15:0]          idle_cnt_reg;
	logic [15:0]          silence_reg;
	cml_esc_state_t       esc_state_reg;
	cml_esc_state_t       esc_state_next;
	logic [1:0]           esc_cnt_reg;
	logic [1:0]           esc_cnt_next;
	logic [`CML_IRQ_W-1:0] irq_status_reg;
	logic [`CML_IRQ_W-1:0] irq_enable_reg;
	logic                 irq_reg;
	logic [7:0]           join_code;
	logic [31:0]          rd_mux;
	logic                 rd_hit;

	// APB decode; access completes on the second cycle of the access phase
	wire acc    = psel_i & penable_i & pready_reg;
	wire wr_en  = acc & pwrite_i;
	wire wr_hold  = wr_en & (paddr_i == `CML_OFS_HOLD_TIME);
	wire wr_tmo   = wr_en & (paddr_i == `CML_OFS_IDLE_TIMEOUT);
	wire wr_guard = wr_en & (paddr_i == `CML_OFS_GUARD_TIME);
	wire wr_esc   = wr_en & (paddr_i == `CML_OFS_ESC_CHAR);
	wire wr_clr   = wr_en & (paddr_i == `CML_OFS_IRQ_CLEAR);
	wire wr_ien   = wr_en & (paddr_i == `CML_OFS_IRQ_ENABLE);

	// Out-of-range settings are ignored so the stored value stays legal
	wire hold_ok = (pwdata_i[7:0] >= `CML_HOLD_MIN);
	wire tmo_ok  = (pwdata_i[15:0] >= `CML_TIMEOUT_MIN);

	always_comb
	begin
		rd_hit = 1'b1;
		case (paddr_i)
			`CML_OFS_HW_REV:       rd_mux = {16'h0000, HW_REV};
			`CML_OFS_RX_FAULT:     rd_mux = {16'h0000, sat_cnt_reg[0]};
			`CML_OFS_RX_GOOD:      rd_mux = {16'h0000, sat_cnt_reg[1]};
			`CML_OFS_TX_FAIL:      rd_mux = {16'h0000, sat_cnt_reg[2]};
			`CML_OFS_HOLD_TIME:    rd_mux = {24'h000000, hold_time_reg};
			`CML_OFS_JOIN_STATUS:  rd_mux = {24'h000000, join_status_reg};
			`CML_OFS_IDLE_TIMEOUT: rd_mux = {16'h0000, idle_timeout_reg};
			`CML_OFS_GUARD_TIME:   rd_mux = {16'h0000, guard_time_reg};
			`CML_OFS_ESC_CHAR:     rd_mux = {24'h000000, esc_char_reg};
			`CML_OFS_MODE:         rd_mux = {31'h00000000, cmd_mode_reg};
			`CML_OFS_IRQ_STATUS:   rd_mux = {29'h00000000, irq_status_reg};
			`CML_OFS_IRQ_CLEAR:    rd_mux = 32'h00000000;
			`CML_OFS_IRQ_ENABLE:   rd_mux = {29'h00000000, irq_enable_reg};
			default:
			begin
				rd_mux = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			pready_reg  <= psel_i & penable_i & ~pready_reg;
			prdata_reg  <= (psel_i & penable_i & ~pwrite_i) ? rd_mux
				: 32'h00000000;
			pslverr_reg <= psel_i & penable_i & ~pready_reg & ~rd_hit;
		end
	end

	// Saturating event counters: fault, good, transmit failure
	wire [2:0] cnt_evt = {tx_fail_i, rx_good_i, rx_fault_i};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_cnt
			always_ff @(posedge core_clk_i)
			begin
				if (!reset_n_i)
					sat_cnt_reg[gi] <= 16'h0000;
				else if (cnt_evt[gi] && sat_cnt_reg[gi] != `CML_SAT_MAX)
					sat_cnt_reg[gi] <= sat_cnt_reg[gi] + 16'h0001;
			end
		end
	endgenerate

	// Settings
	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			hold_time_reg    <= `CML_HOLD_RST;
			idle_timeout_reg <= `CML_TIMEOUT_RST;
			guard_time_reg   <= `CML_GUARD_RST;
			esc_char_reg     <= `CML_ESC_RST;
			irq_enable_reg   <= 3'h0;
		end
		else
		begin
			if (wr_hold && hold_ok)
				hold_time_reg <= pwdata_i[7:0];
			if (wr_tmo && tmo_ok)
				idle_timeout_reg <= pwdata_i[15:0];
			if (wr_guard)
				guard_time_reg <= pwdata_i[15:0];
			if (wr_esc)
				esc_char_reg <= pwdata_i[7:0];
			if (wr_ien)
				irq_enable_reg <= pwdata_i[`CML_IRQ_W-1:0];
		end
	end

	// Signal strength hold in 100 ms steps; may end up to one step early
	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			hold_cnt_reg <= 8'h00;
			strength_reg <= 1'b0;
		end
		else
		begin
			if (rx_frame_i)
				hold_cnt_reg <= hold_time_reg;
			else if (tick.deci_tick && hold_cnt_reg != 8'h00)
				hold_cnt_reg <= hold_cnt_reg - 8'h01;
			strength_reg <= (hold_cnt_reg != 8'h00);
		end
	end

	// Join status code mapping
	always_comb
	begin
		case (join_event_i)
			JE_JOINED:      join_code = `CML_JS_OK;
			JE_NO_NET:      join_code = `CML_JS_NO_NET;
			JE_NO_MATCH:    join_code = `CML_JS_NO_MATCH;
			JE_REFUSED:     join_code = `CML_JS_REFUSED;
			JE_JOIN_FAIL:   join_code = `CML_JS_JOIN_FAIL;
			JE_COORD_FAIL:  join_code = `CML_JS_COORD_FAIL;
			JE_COORD_CHECK: join_code = `CML_JS_COORD_CHECK;
			JE_NO_RESP:     join_code = `CML_JS_NO_RESP;
			JE_KEY_UNSEC:   join_code = `CML_JS_KEY_UNSEC;
			default:        join_code = `CML_JS_SCANNING;
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
			join_status_reg <= `CML_JS_SCANNING;
		else if (join_event_valid_i)
			join_status_reg <= join_code;
	end

	// Escape detection: silence counted in ms since the last byte
	wire guard_met = (silence_reg >= guard_time_reg);
	wire esc_byte  = rx_byte_valid_i & (rx_byte_i == esc_char_reg);

	always_comb
	begin
		esc_state_next = esc_state_reg;
		esc_cnt_next   = esc_cnt_reg;
		case (esc_state_reg)
			ESC_IDLE:
				if (esc_byte && guard_met && !cmd_mode_reg)
				begin
					esc_state_next = ESC_SEEN;
					esc_cnt_next   = 2'h1;
				end
			ESC_SEEN:
				if (rx_byte_valid_i && !esc_byte)
					esc_state_next = ESC_IDLE;
				else if (esc_byte && esc_cnt_reg == `CML_ESC_COUNT - 2'h1)
					esc_state_next = ESC_POST;
				else if (esc_byte)
					esc_cnt_next = esc_cnt_reg + 2'h1;
			ESC_POST:
				if (rx_byte_valid_i || guard_met)
					esc_state_next = ESC_IDLE;
			default:
				esc_state_next = ESC_IDLE;
		endcase
	end

	// A post-guard byte cancels; silence alone completes the sequence
	wire esc_done = (esc_state_reg == ESC_POST) & ~rx_byte_valid_i
		& guard_met;
	wire tmo_hit  = cmd_mode_reg & tick.deci_tick
		& (idle_cnt_reg == 16'h0001);
	wire leave    = cmd_mode_reg & (cmd_exit_i | tmo_hit);

	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			esc_state_reg <= ESC_IDLE;
			esc_cnt_reg   <= 2'h0;
			silence_reg   <= 16'h0000;
			cmd_mode_reg  <= 1'b0;
			idle_cnt_reg  <= 16'h0000;
		end
		else
		begin
			esc_state_reg <= esc_state_next;
			esc_cnt_reg   <= esc_cnt_next;
			if (rx_byte_valid_i)
				silence_reg <= 16'h0000;
			else if (tick.ms_tick && silence_reg != 16'hFFFF)
				silence_reg <= silence_reg + 16'h0001;
			if (leave)
				cmd_mode_reg <= 1'b0;
			else if (esc_done)
				cmd_mode_reg <= 1'b1;
			if (esc_done || (cmd_mode_reg && cmd_valid_i))
				idle_cnt_reg <= idle_timeout_reg;
			else if (cmd_mode_reg && tick.deci_tick)
				idle_cnt_reg <= idle_cnt_reg - 16'h0001;
		end
	end

	// Interrupts; a new event beats a clear in the same cycle
	wire [`CML_IRQ_W-1:0] irq_evt = {join_event_valid_i, leave,
		esc_done & ~cmd_mode_reg};
	wire [`CML_IRQ_W-1:0] irq_clr = wr_clr ? pwdata_i[`CML_IRQ_W-1:0]
		: 3'h0;

	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			irq_status_reg <= 3'h0;
			irq_reg        <= 1'b0;
		end
		else
		begin
			irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_evt;
			irq_reg        <= |(irq_status_reg & irq_enable_reg);
		end
	end

	assign prdata_o   = prdata_reg;
	assign pready_o   = pready_reg;
	assign pslverr_o  = pslverr_reg;
	assign cmd_mode_o = cmd_mode_reg;
	assign strength_o = strength_reg;
	assign irq_o      = irq_reg;

	hw_rev_read_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		psel_i && penable_i && !pwrite_i && !pready_reg
		&& paddr_i == `CML_OFS_HW_REV |=> prdata_o[15:0] == HW_REV)
		else $error("hardware revision read wrong");
	fault_sat_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		sat_cnt_reg[0] == `CML_SAT_MAX |=> sat_cnt_reg[0] == `CML_SAT_MAX)
		else $error("fault counter wrapped");
	good_count_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		rx_good_i && sat_cnt_reg[1] != `CML_SAT_MAX
		|=> sat_cnt_reg[1] == $past(sat_cnt_reg[1]) + 16'h0001)
		else $error("good counter missed a frame");
	tx_fail_sat_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		sat_cnt_reg[2] == `CML_SAT_MAX |=> sat_cnt_reg[2] == `CML_SAT_MAX)
		else $error("transmit failure counter wrapped");
	strength_on_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		rx_frame_i |-> ##2 strength_o)
		else $error("strength output not raised");
	join_ok_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		join_event_valid_i && join_event_i == JE_JOINED
		|=> join_status_reg == `CML_JS_OK)
		else $error("join success not reported as zero");
	join_unsec_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		join_event_valid_i && join_event_i == JE_KEY_UNSEC
		|=> join_status_reg == `CML_JS_KEY_UNSEC)
		else $error("unsecured key code wrong");
	exit_cmd_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		cmd_mode_o && cmd_exit_i |=> !cmd_mode_o)
		else $error("exit command ignored");
	idle_tmo_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		cmd_mode_reg && tick.deci_tick && idle_cnt_reg == 16'h0001
		|=> !cmd_mode_o)
		else $error("inactivity timeout ignored");
	esc_cancel_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		esc_state_reg == ESC_SEEN && rx_byte_valid_i && !esc_byte
		|=> esc_state_reg == ESC_IDLE ##1 !cmd_mode_o)
		else $error("foreign byte did not cancel escape");
	esc_enter_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		esc_done && !cmd_exit_i |=> cmd_mode_o
		&& idle_cnt_reg == $past(idle_timeout_reg))
		else $error("guarded escape did not enter command mode");
endmodule
`default_nettype wire

// file: hdl/cml_pkg.sv
// Purpose: shared types for the command mode and link diagnostics block
// Assumes: nothing
// Notes:   numeric constants live in cml_cfg.svh
package cml_pkg;

	typedef enum logic [1:0]
	{
		ESC_IDLE = 2'b00,
		ESC_SEEN = 2'b01,
		ESC_POST = 2'b10
	} cml_esc_state_t;

	typedef enum logic [3:0]
	{
		JE_JOINED      = 4'b0000,
		JE_NO_NET      = 4'b0001,
		JE_NO_MATCH    = 4'b0010,
		JE_REFUSED     = 4'b0011,
		JE_JOIN_FAIL   = 4'b0100,
		JE_COORD_FAIL  = 4'b0101,
		JE_COORD_CHECK = 4'b0110,
		JE_NO_RESP     = 4'b0111,
		JE_KEY_UNSEC   = 4'b1000,
		JE_SCANNING    = 4'b1001
	} cml_join_evt_t;

endpackage

// file: hdl/cml_tick_if.sv
// Purpose: timebase pulses from the tick generator to the core
// Assumes: single clock domain
// Notes:   each tick is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface cml_tick_if;
	logic ms_tick;
	logic deci_tick;
	modport src (output ms_tick, output deci_tick);
	modport dst (input ms_tick, input deci_tick);
endinterface
`default_nettype wire

// file: hdl/cml_timebase.sv
// Purpose: millisecond and 100 ms tick generator
// Assumes: synchronous active-low reset
// Notes:   deci tick coincides with every hundredth ms tick
`timescale 1ns/1ps
`default_nettype none
`include "cml_cfg.svh"
module cml_timebase
	import cml_pkg::*;
#(
	parameter int MS_CYCLES = `CML_MS_CYCLES
)
(
	input  wire logic  core_clk_i,
	input  wire logic  reset_n_i,
	cml_tick_if.src    tick
);
	logic [17:0] cyc_reg;
	logic [6:0]  ms_reg;
	logic        ms_reg_tick;
	logic        deci_reg_tick;
	wire         cyc_wrap = (cyc_reg == 18'(MS_CYCLES - 1));
	wire         ms_wrap  = (ms_reg == 7'(`CML_DECI_MS_TICKS - 1));

	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			cyc_reg       <= 18'h00000;
			ms_reg        <= 7'h00;
			ms_reg_tick   <= 1'b0;
			deci_reg_tick <= 1'b0;
		end
		else
		begin
			cyc_reg       <= cyc_wrap ? 18'h00000 : cyc_reg + 18'h00001;
			ms_reg_tick   <= cyc_wrap;
			deci_reg_tick <= cyc_wrap & ms_wrap;
			if (cyc_wrap)
				ms_reg <= ms_wrap ? 7'h00 : ms_reg + 7'h01;
		end
	end

	assign tick.ms_tick   = ms_reg_tick;
	assign tick.deci_tick = deci_reg_tick;

	period_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		ms_reg_tick |=> !ms_reg_tick)
		else $error("ms tick longer than one cycle");
endmodule
`default_nettype wire

// file: tb/cmd_mode_and_link_diagnostics_bench.sv
// Purpose: self-checking bench for command mode and link diagnostics
// Assumes: MS_CYCLES of 2, so 100 ms is 200 cycles
// Notes:   the counter saturation run dominates the run time
`timescale 1ns/1ps
`default_nettype none
`include "cml_cfg.svh"
module cmd_mode_and_link_diagnostics_bench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  rx_byte;
	logic        rx_vld;
	logic        cmd_vld;
	logic        cmd_ex;
	logic        rx_fault = 1'b0;
	logic        rx_good = 1'b0;
	logic        tx_fail = 1'b0;
	logic        rx_frame = 1'b0;
	logic        jv = 1'b0;
	logic [3:0]  je = 4'h0;
	logic        cmd_mode;
	logic        strength;
	logic        irq;
	int          fails = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          nf, ng, nt, i;
	logic [31:0] seed = 32'h21A4;
	logic [31:0] rd;
	logic        er;
	logic [7:0]  ch;

	always #2.5 clk = ~clk;

	cml_core #(.MS_CYCLES(2), .HW_REV(16'h5A3C)) i_dut ( // Arbitrary rev
		.core_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .rx_byte_i(rx_byte), .rx_byte_valid_i(rx_vld),
		.cmd_valid_i(cmd_vld), .cmd_exit_i(cmd_ex), .rx_fault_i(rx_fault),
		.rx_good_i(rx_good), .tx_fail_i(tx_fail), .rx_frame_i(rx_frame),
		.join_event_valid_i(jv), .join_event_i(je), .cmd_mode_o(cmd_mode),
		.strength_o(strength), .irq_o(irq));

	cml_host_model i_host (.clk_i(clk), .rx_byte_o(rx_byte),
		.rx_byte_valid_o(rx_vld), .cmd_valid_o(cmd_vld),
		.cmd_exit_o(cmd_ex));

	function automatic logic [31:0] nxt(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic [31:0] js(input logic [3:0] e);
		case (e)
			4'h0: return 32'h00;
			4'h1: return 32'h21;
			4'h2: return 32'h22;
			4'h3: return 32'h23;
			4'h4: return 32'h27;
			4'h5: return 32'h2A;
			4'h6: return 32'h2B;
			4'h7: return 32'hAB;
			4'h8: return 32'hAC;
			default: return 32'hFF;
		endcase
	endfunction

	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask

	// Request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// No local limit: only the bench timeout ends a hung access
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input string n, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, rd, e);
	endtask

	task automatic wait_mode(input logic v);
		int n;
		n = 0;
		while (cmd_mode !== v && n < 60)
		begin
			@(posedge clk);
			n++;
		end
	endtask

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 90000)
		begin
			fails++;
			conclude();
		end
	end

	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rdc("hw_rev", `CML_OFS_HW_REV, 32'h5A3C);
		apb(1'b1, `CML_OFS_HW_REV, 32'h1234);
		rdc("hw_rev_ro", `CML_OFS_HW_REV, 32'h5A3C);
		rdc("hold_rst", `CML_OFS_HOLD_TIME, 32'h20);
		rdc("tmo_rst", `CML_OFS_IDLE_TIMEOUT, 32'h64);
		rdc("guard_rst", `CML_OFS_GUARD_TIME, 32'h3E8);
		rdc("esc_rst", `CML_OFS_ESC_CHAR, 32'h2B);
		rdc("join_rst", `CML_OFS_JOIN_STATUS, 32'hFF);
		rdc("unmapped", 8'h3C, 32'h0);
		chk("unmapped_err", {31'h0, er}, 32'h1);
		$display("test registers done");

		nf = 0;
		ng = 0;
		nt = 0;
		repeat (300)
		begin
			seed = nxt(seed);
			@(posedge clk);
			rx_fault <= seed[0];
			rx_good <= seed[5];
			tx_fail <= seed[9];
			nf += seed[0];
			ng += seed[5];
			nt += seed[9];
		end
		@(posedge clk);
		rx_fault <= 1'b0;
		rx_good <= 1'b0;
		tx_fail <= 1'b0;
		rdc("rx_fault", `CML_OFS_RX_FAULT, nf);
		rdc("rx_good", `CML_OFS_RX_GOOD, ng);
		rdc("tx_fail", `CML_OFS_TX_FAIL, nt);
		// Held high, one count per edge, long enough to pass the top
		@(posedge clk);
		rx_fault <= 1'b1;
		rx_good <= 1'b1;
		tx_fail <= 1'b1;
		repeat (65540) @(posedge clk);
		rx_fault <= 1'b0;
		rx_good <= 1'b0;
		tx_fail <= 1'b0;
		rdc("rx_fault_sat", `CML_OFS_RX_FAULT, 32'hFFFF);
		rdc("rx_good_sat", `CML_OFS_RX_GOOD, 32'hFFFF);
		rdc("tx_fail_sat", `CML_OFS_TX_FAIL, 32'hFFFF);
		$display("test counters done");

		for (i = 10; i >= 0; i--)
		begin
			@(posedge clk);
			je <= (i == 10) ? 4'hF : 4'(i);
			jv <= 1'b1;
			@(posedge clk);
			jv <= 1'b0;
			rdc("join_code", `CML_OFS_JOIN_STATUS, js(je));
		end
		i = 0;
		do
		begin
			apb(1'b0, `CML_OFS_JOIN_STATUS, 32'h0);
			i++;
		end
		while (rd !== 32'h0 && i < 8);
		chk("join_poll", rd, 32'h0);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		apb(1'b1, `CML_OFS_IRQ_ENABLE, 32'h4);
		repeat (3) @(posedge clk);
		chk("irq_join", {31'h0, irq}, 32'h1);
		apb(1'b1, `CML_OFS_IRQ_CLEAR, 32'h4);
		repeat (3) @(posedge clk);
		chk("irq_clear", {31'h0, irq}, 32'h0);
		rdc("irq_status", `CML_OFS_IRQ_STATUS, 32'h0);
		$display("test join done");

		seed = nxt(seed);
		ch = seed[7:0];
		apb(1'b1, `CML_OFS_GUARD_TIME, 32'h3);
		apb(1'b1, `CML_OFS_ESC_CHAR, {24'h0, ch});
		apb(1'b1, `CML_OFS_IRQ_ENABLE, 32'h3);
		i_host.send({ch, ch, ch ^ 8'h01, ch});
		repeat (20) @(posedge clk);
		i_host.send({ch, ch, ch ^ 8'h01, ch});
		repeat (40) @(posedge clk);
		chk("cancel_byte", {31'h0, cmd_mode}, 32'h0);
		// Foreign byte just before, so the pre-silence is too short
		i_host.send({ch ^ 8'h01});
		i_host.escape(ch, 1);
		repeat (40) @(posedge clk);
		chk("short_pre", {31'h0, cmd_mode}, 32'h0);
		i_host.escape(ch, 20);
		repeat (2) @(posedge clk);
		i_host.send({ch ^ 8'h01});
		repeat (40) @(posedge clk);
		chk("short_post", {31'h0, cmd_mode}, 32'h0);
		i_host.escape(ch, 20);
		@(posedge clk);
		chk("post_guard", {31'h0, cmd_mode}, 32'h0);
		wait_mode(1'b1);
		chk("enter", {31'h0, cmd_mode}, 32'h1);
		rdc("mode_reg", `CML_OFS_MODE, 32'h1);
		repeat (3) @(posedge clk);
		chk("irq_enter", {31'h0, irq}, 32'h1);
		i_host.strobe(1'b1);
		@(posedge clk);
		chk("exit_cmd", {31'h0, cmd_mode}, 32'h0);
		rdc("irq_both", `CML_OFS_IRQ_STATUS, 32'h3);
		apb(1'b1, `CML_OFS_IRQ_CLEAR, 32'h7);
		$display("test escape done");

		apb(1'b1, `CML_OFS_IDLE_TIMEOUT, 32'h1);
		apb(1'b1, `CML_OFS_IDLE_TIMEOUT, 32'h2);
		rdc("tmo_min", `CML_OFS_IDLE_TIMEOUT, 32'h2);
		// Three steps: leaving falls 401 to 600 cycles after a reload
		apb(1'b1, `CML_OFS_IDLE_TIMEOUT, 32'h3);
		i_host.escape(ch, 20);
		wait_mode(1'b1);
		repeat (340) @(posedge clk);
		i_host.strobe(1'b0);
		repeat (380) @(posedge clk);
		chk("restart", {31'h0, cmd_mode}, 32'h1);
		repeat (240) @(posedge clk);
		chk("timeout", {31'h0, cmd_mode}, 32'h0);
		$display("test timeout done");

		apb(1'b1, `CML_OFS_HOLD_TIME, 32'h0);
		rdc("hold_min", `CML_OFS_HOLD_TIME, 32'h20);
		apb(1'b1, `CML_OFS_HOLD_TIME, 32'h2);
		chk("strength_idle", {31'h0, strength}, 32'h0);
		@(posedge clk);
		rx_frame <= 1'b1;
		@(posedge clk);
		rx_frame <= 1'b0;
		repeat (180) @(posedge clk);
		chk("strength_on", {31'h0, strength}, 32'h1);
		repeat (240) @(posedge clk);
		chk("strength_off", {31'h0, strength}, 32'h0);
		$display("test strength done");
		conclude();
	end
endmodule
`default_nettype wire

// file: tb/cml_host_model.sv
// Purpose: host side model driving serial bytes and command strobes
// Assumes: bytes are one-cycle valid pulses, back to back allowed
// Notes:   idle byte lane shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module cml_host_model
(
	input  wire logic       clk_i,
	output var  logic [7:0] rx_byte_o,
	output var  logic       rx_byte_valid_o,
	output var  logic       cmd_valid_o,
	output var  logic       cmd_exit_o
);
	initial
	begin
		rx_byte_o = 8'hA5;
		rx_byte_valid_o = 1'b0;
		cmd_valid_o = 1'b0;
		cmd_exit_o = 1'b0;
	end

	// Stale data on the lane would hide a stuck valid
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i])
		begin
			@(posedge clk_i);
			rx_byte_o <= q[i];
			rx_byte_valid_o <= 1'b1;
		end
		@(posedge clk_i);
		rx_byte_o <= ~q[q.size()-1];
		rx_byte_valid_o <= 1'b0;
	endtask

	// Silence first, then three escapes with no byte between
	task automatic escape(input logic [7:0] ch, input int gap);
		repeat (gap) @(posedge clk_i);
		send({ch, ch, ch});
	endtask

	task automatic strobe(input logic ex);
		@(posedge clk_i);
		if (ex)
			cmd_exit_o <= 1'b1;
		else
			cmd_valid_o <= 1'b1;
		@(posedge clk_i);
		cmd_exit_o <= 1'b0;
		cmd_valid_o <= 1'b0;
	endtask
endmodule
`default_nettype wire
